// ---- event_channel.sv ----
// one external event channel: pin synchroniser, pending and error flags
// assumes event_pin is asynchronous; clear comes from a status read
`timescale 1ns/1ns
module event_channel #(
   parameter bit COUNT_PATH = 1'b0
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // outside event
   input wire logic event_pin,
   // control from the clock core
   input wire logic clear,
   input wire logic inhibit,
   // flags and strobes
   output logic pending,
   output logic error,
   output logic event_pulse,
   output logic count_pulse
);
   logic s1, s2, s3, level, arrive, take;

   // three-stage synchroniser; s1 feeds only s2
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         level <= 1'b0;
      end else begin
         s1 <= event_pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) level <= s2;
      end
   end

   // arrival waits out a sequencer inhibit rather than being lost
   assign take = arrive && !inhibit;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) arrive <= 1'b0;
      else if (s2 && s3 && !level) arrive <= 1'b1;
      else if (take) arrive <= 1'b0;
   end

   // second event before clearing marks an error; set beats clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pending <= 1'b0;
         error <= 1'b0;
         event_pulse <= 1'b0;
      end else begin
         event_pulse <= take;
         if (take) begin
            pending <= 1'b1;
            if (pending) error <= 1'b1;
         end else if (clear) begin
            pending <= 1'b0;
            error <= 1'b0;
         end
      end
   end

   // only the counting channel has a direct path to the counter
   assign count_pulse = COUNT_PATH && event_pulse;

   property p_clear_flags;
      @(posedge hclk) disable iff (!hresetn)
      clear && !take |=> !pending && !error;
   endproperty
   a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared");

   property p_error_on_second;
      @(posedge hclk) disable iff (!hresetn)
      take && pending |=> error && pending;
   endproperty
   a_error_on_second: assert property (p_error_on_second) else $error("no error");

   property p_count_path;
      @(posedge hclk) disable iff (!hresetn)
      !COUNT_PATH |-> !count_pulse;
   endproperty
   a_count_path: assert property (p_count_path) else $error("bad count path");
endmodule

// ---- event_source.sv ----
// event source model standing at the pins of the interval clock
// assumes pins idle low; an event is a rising edge held about 1 us
`timescale 1ns/1ns
module event_source (
   // clock
   input wire logic hclk,
   // pins to the clock block
   output logic [2:0] event_in
);
   // pins start idle so no event is seen out of reset
   initial event_in = 3'h0;

   // held 100 cycles so the synchroniser cannot miss it, then idle as long
   task automatic fire(input int ch);
      @(posedge hclk);
      event_in[ch] <= 1'b1;
      repeat (100) @(posedge hclk);
      event_in[ch] <= 1'b0;
      repeat (100) @(posedge hclk);
   endtask
endmodule

// ---- pic_pkg.sv ----
// constants shared by the interval clock and its event channels
// assumes a single 100 MHz bus clock and AHB-Lite word access
package pic_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_ENABLE = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_BUFFER = 8'h0c;
   localparam logic [7:0] OFF_COUNT = 8'h10;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
   // control word fields
   localparam int RATE_LSB = 0;
   localparam int MODE0_BIT = 3;
   localparam int MODE1_BIT = 4;
   localparam int MODE2_BIT = 5;
   // enable word fields
   localparam int EN_OVF_BIT = 0;
   localparam int EN_SKIP_BIT = 1;
   // status word fields
   localparam int ST_OVF_BIT = 0;
   localparam int ST_PEND_LSB = 1;
   localparam int ST_ERR_LSB = 4;
   // reset values and the full count
   localparam logic [11:0] COUNT_RST = 12'h000;
   localparam logic [11:0] BUFFER_RST = 12'h000;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   localparam logic [11:0] COUNT_FULL = 12'hfff;
   // time base: 400 kHz source from the bus clock, then /4, then decades
   localparam int CLK_PERIOD_NS = 10;
   localparam int OSC_PERIOD_NS = 2500;
   localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0] OSC_DIV_LAST = 8'(OSC_DIV - 1);
   localparam logic [1:0] BIN_LAST = 2'h3;
   localparam logic [3:0] DEC_LAST = 4'h9;
   typedef enum logic [2:0] {
      RATE_STOP = 3'h0,
      RATE_400K = 3'h1,
      RATE_100K = 3'h2,
      RATE_10K = 3'h3,
      RATE_1K = 3'h4,
      RATE_100 = 3'h5,
      RATE_EVENT = 3'h6,
      RATE_OFF = 3'h7
   } rate_t;
endpackage

// ---- programmable_interval_clock.sv ----
// programmable interval clock: 12-bit counter, preset buffer, time base
// assumes one AHB-Lite master, 100 MHz hclk, asynchronous event pins
// Operation
// - only channel one may advance the counter from an outside event
// - status read returns the overflow and channel flags
// - overflow interrupt enable gates overflow onto the interrupt request
// - enabling skip always enables the interrupt request too
// - counter is 12 bits, loadable from and copyable to buffer
// - mode 1 copies counter into buffer on each event except at rate 6
// - mode 1 clear, mode 2 set reloads counter from buffer on overflow
// - software reads and writes the preset buffer
// - counts events and intervals from 2.5 us to over 40 s
// - rate field selects the increment frequency through a decoder
// - mode flags load from control word bits 3 to 5
// - mode 0 starts conversion at load, else at each overflow
// - overflow flag sets at 4096 counts and requests interrupt when enabled
// - 400 kHz divided by four to 100 kHz, then three decades
// - rate 6 counts channel one events and suppresses buffer copies
// - status read clears channel flags; double event leaves error set
// - buffer and counter reads inhibit the sequencer during the read
`timescale 1ns/1ns
module programmable_interval_clock #(
   parameter int CHANNELS = 3
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // event pins
   input wire logic [CHANNELS-1:0] event_in,
   // requests to processor and converter
   output logic clock_irq_request,
   output logic clock_skip_request,
   output logic ad_start,
   output logic irq
);
   import pic_pkg::*;

   if (CHANNELS != 3) begin : g_chk
      $error("CHANNELS must be 3");
   end

   function automatic logic [3:0] dec_step(input logic [3:0] v);
      dec_step = (v == DEC_LAST) ? 4'h0 : 4'(v + 4'h1);
   endfunction

   rate_t rate;
   logic [2:0] mode;
   logic overflow_irq_enable, skip_enable, overflow_flag;
   logic [11:0] count_register, buffer;
   logic [3:0] irq_status, irq_mask;
   logic [2:0] ch_pend, ch_err, ch_event, ch_count;
   logic wr_pend;
   logic [7:0] wr_addr, a;
   logic acc, rd_acc, rd_sync, sync_inhibit;
   logic status_read_instr, buffer_read_instr, counter_read_instr;
   logic control_word_load_instr, interrupt_enable_load_instr;
   logic buffer_write, irq_status_write, irq_mask_write;
   logic [31:0] next_rdata;
   logic [7:0] presc;
   logic [1:0] bin;
   logic [3:0] d0, d1, d2;
   logic osc_tick, t100k, t10k, t1k, t100, rate_tick;
   logic inc_pend, cap_pend, do_inc, do_cap, overflow_event, counter_load_pulse;
   logic increment_pulse_flag;

   // zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign acc = hsel && hready && htrans[1];
   assign rd_acc = acc && !hwrite;
   assign a = haddr[7:0];
   assign status_read_instr = rd_acc && a == OFF_STATUS;
   assign buffer_read_instr = rd_acc && a == OFF_BUFFER;
   assign counter_read_instr = rd_acc && a == OFF_COUNT;
   assign control_word_load_instr = wr_pend && wr_addr == OFF_CONTROL;
   assign interrupt_enable_load_instr = wr_pend && wr_addr == OFF_ENABLE;
   assign buffer_write = wr_pend && wr_addr == OFF_BUFFER;
   assign irq_status_write = wr_pend && wr_addr == OFF_IRQ_STATUS;
   assign irq_mask_write = wr_pend && wr_addr == OFF_IRQ_MASK;

   // write address held over to the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= acc && hwrite;
         wr_addr <= a;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (a)
         OFF_CONTROL: next_rdata[5:0] = {mode, rate};
         OFF_ENABLE: next_rdata[1:0] = {skip_enable, overflow_irq_enable};
         OFF_STATUS: next_rdata[6:0] = {ch_err, ch_pend, overflow_flag};
         OFF_BUFFER: next_rdata[11:0] = buffer;
         OFF_COUNT: next_rdata[11:0] = count_register;
         OFF_IRQ_STATUS: next_rdata[3:0] = irq_status;
         OFF_IRQ_MASK: next_rdata[3:0] = irq_mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // read data sampled at the address phase so it is stable in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hrdata <= 32'h0000_0000;
      else if (rd_acc) hrdata <= next_rdata;
   end

   // sequencer held off for the whole buffer or counter read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) rd_sync <= 1'b0;
      else rd_sync <= buffer_read_instr || counter_read_instr;
   end
   assign sync_inhibit = buffer_read_instr || counter_read_instr || rd_sync;

   // control word: rate and mode flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rate <= RATE_STOP;
         mode <= MODE_RST;
      end else if (control_word_load_instr) begin
         rate <= rate_t'(hwdata[RATE_LSB +: 3]);
         mode <= hwdata[MODE2_BIT:MODE0_BIT];
      end
   end

   // enable word; skip drags interrupt enable with it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overflow_irq_enable <= 1'b0;
         skip_enable <= 1'b0;
      end else if (interrupt_enable_load_instr) begin
         overflow_irq_enable <= hwdata[EN_OVF_BIT] || hwdata[EN_SKIP_BIT];
         skip_enable <= hwdata[EN_SKIP_BIT];
      end
   end

   // time base: 400 kHz, two binary stages, three decades
   assign osc_tick = presc == OSC_DIV_LAST;
   assign t100k = osc_tick && bin == BIN_LAST;
   assign t10k = t100k && d0 == DEC_LAST;
   assign t1k = t10k && d1 == DEC_LAST;
   assign t100 = t1k && d2 == DEC_LAST;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc <= 8'h00;
         bin <= 2'h0;
         d0 <= 4'h0;
         d1 <= 4'h0;
         d2 <= 4'h0;
      end else begin
         presc <= osc_tick ? 8'h00 : 8'(presc + 8'h01);
         if (osc_tick) bin <= 2'(bin + 2'h1);
         if (t100k) d0 <= dec_step(d0);
         if (t10k) d1 <= dec_step(d1);
         if (t1k) d2 <= dec_step(d2);
      end
   end

   // rate decoder; slowest rate gives 4096 x 10 ms, just over 40 s
   always_comb begin
      unique case (rate)
         RATE_STOP: rate_tick = 1'b0;
         RATE_400K: rate_tick = osc_tick;
         RATE_100K: rate_tick = t100k;
         RATE_10K: rate_tick = t10k;
         RATE_1K: rate_tick = t1k;
         RATE_100: rate_tick = t100;
         RATE_EVENT: rate_tick = ch_count[0];
         RATE_OFF: rate_tick = 1'b0;
      endcase
   end

   // event channels; only the first may drive the counter
   for (genvar i = 0; i < 3; i++) begin : g_ch
      event_channel #(
         .COUNT_PATH(i == 0)
      ) u_ch (
         .hclk(hclk),
         .hresetn(hresetn),
         .event_pin(event_in[i]),
         .clear(status_read_instr),
         .inhibit(sync_inhibit),
         .pending(ch_pend[i]),
         .error(ch_err[i]),
         .event_pulse(ch_event[i]),
         .count_pulse(ch_count[i])
      );
   end

   // increments and captures wait while the sequencer is inhibited
   assign do_inc = inc_pend && !sync_inhibit;
   assign do_cap = cap_pend && !sync_inhibit;
   assign increment_pulse_flag = do_inc;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         inc_pend <= 1'b0;
         cap_pend <= 1'b0;
      end else begin
         if (rate_tick) inc_pend <= 1'b1;
         else if (do_inc) inc_pend <= 1'b0;
         if (mode[1] && rate != RATE_EVENT && |ch_event) cap_pend <= 1'b1;
         else if (do_cap || rate == RATE_EVENT) cap_pend <= 1'b0;
      end
   end

   // counter; a control word load presets it from the buffer
   assign counter_load_pulse = control_word_load_instr;
   assign overflow_event = do_inc && count_register == COUNT_FULL;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) count_register <= COUNT_RST;
      else if (counter_load_pulse) count_register <= buffer;
      else if (overflow_event) count_register <= (mode[2] && !mode[1]) ? buffer : 12'h000;
      else if (increment_pulse_flag) count_register <= 12'(count_register + 12'h001);
   end

   // buffer; software write wins over an event capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) buffer <= BUFFER_RST;
      else if (buffer_write) buffer <= hwdata[11:0];
      else if (do_cap) buffer <= count_register;
   end

   // overflow flag: set wins over the status-read clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) overflow_flag <= 1'b0;
      else if (overflow_event) overflow_flag <= 1'b1;
      else if (status_read_instr) overflow_flag <= 1'b0;
   end

   // requests to the processor and converter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clock_irq_request <= 1'b0;
         clock_skip_request <= 1'b0;
         ad_start <= 1'b0;
      end else begin
         clock_irq_request <= overflow_flag && overflow_irq_enable;
         clock_skip_request <= overflow_flag && skip_enable;
         ad_start <= (control_word_load_instr && hwdata[MODE0_BIT]) ||
                     (!mode[0] && overflow_event);
      end
   end

   // sticky interrupt status, write one to clear, set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) irq_status <= 4'h0;
      else irq_status <= (irq_status & ~(irq_status_write ? hwdata[3:0] : 4'h0)) |
                         {ch_event, overflow_event};
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) irq_mask <= IRQ_MASK_RST;
      else if (irq_mask_write) irq_mask <= hwdata[3:0];
   end
   assign irq = |(irq_status & irq_mask);

   property p_skip_needs_irq;
      @(posedge hclk) disable iff (!hresetn)
      skip_enable |-> overflow_irq_enable;
   endproperty
   a_skip_needs_irq: assert property (p_skip_needs_irq) else $error("skip alone");

   property p_overflow_sets;
      @(posedge hclk) disable iff (!hresetn)
      overflow_event |=> overflow_flag;
   endproperty
   a_overflow_sets: assert property (p_overflow_sets) else $error("no overflow");

   property p_irq_request;
      @(posedge hclk) disable iff (!hresetn)
      overflow_event && overflow_irq_enable && !interrupt_enable_load_instr
         |=> ##1 clock_irq_request;
   endproperty
   a_irq_request: assert property (p_irq_request) else $error("no irq request");

   property p_reload;
      @(posedge hclk) disable iff (!hresetn)
      overflow_event && mode[2] && !mode[1] && !counter_load_pulse
         |=> count_register == $past(buffer);
   endproperty
   a_reload: assert property (p_reload) else $error("no reload");

   property p_capture;
      @(posedge hclk) disable iff (!hresetn)
      do_cap && !buffer_write |=> buffer == $past(count_register);
   endproperty
   a_capture: assert property (p_capture) else $error("no capture");

   property p_rate6_nocap;
      @(posedge hclk) disable iff (!hresetn)
      rate == RATE_EVENT |=> !do_cap;
   endproperty
   a_rate6_nocap: assert property (p_rate6_nocap) else $error("capture at rate 6");

   property p_read_inhibit;
      @(posedge hclk) disable iff (!hresetn)
      buffer_read_instr |-> !do_cap ##1 !do_cap && !do_inc;
   endproperty
   a_read_inhibit: assert property (p_read_inhibit) else $error("sequencer ran");

   property p_ad_on_overflow;
      @(posedge hclk) disable iff (!hresetn)
      overflow_event && !mode[0] |=> ad_start;
   endproperty
   a_ad_on_overflow: assert property (p_ad_on_overflow) else $error("no ad start");

   // a decoded tick must be held as a pending increment, never dropped
   property p_fast_rate;
      @(posedge hclk) disable iff (!hresetn)
      rate == RATE_400K && osc_tick |=> inc_pend;
   endproperty
   a_fast_rate: assert property (p_fast_rate) else $error("tick lost");
endmodule

// ---- programmable_interval_clock_tb.sv ----
// self-checking bench: AHB-Lite master tasks and a list of scenarios
// assumes the zero-wait slave and the event source model on the pins
`timescale 1ns/1ns
module programmable_interval_clock_tb;
   import pic_pkg::*;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   wire logic hready;
   logic [2:0] event_in;
   logic clock_irq_request;
   logic clock_skip_request;
   logic ad_start;
   logic irq;
   logic sel = 1'b1;
   int error_cnt = 0;
   int comparisons = 0;
   int ad_cnt = 0;
   int base;
   int per;
   logic [31:0] rd;
   logic [7:0] offs [8] = '{OFF_CONTROL, OFF_ENABLE, OFF_STATUS, OFF_BUFFER,
      OFF_COUNT, OFF_IRQ_STATUS, OFF_IRQ_MASK, 8'h1c};

   // single slave, so its ready is the bus ready
   assign hready = hreadyout;

   programmable_interval_clock i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .event_in(event_in), .clock_irq_request(clock_irq_request),
      .clock_skip_request(clock_skip_request), .ad_start(ad_start), .irq(irq));

   event_source i_src (.hclk(hclk), .event_in(event_in));

   // 100 MHz bus clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // converter start pulses are one cycle wide, so count every one
   always @(posedge hclk) begin
      if (ad_start === 1'b1) begin
         ad_cnt <= ad_cnt + 1;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // address phase held until ready, then data phase held until ready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge hclk);
      hsel <= sel;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask

   // waits are bounded; a missing request then shows in the next check
   task automatic wait_req(input logic skip);
      repeat (1000) begin
         if ((skip ? clock_skip_request : clock_irq_request) !== 1'b1) begin
            @(posedge hclk);
         end
      end
      repeat (3) @(posedge hclk);
   endtask

   // watchdog well past the roughly 16k cycles the scenarios need
   initial begin
      repeat (60000) @(posedge hclk);
      error_cnt++;
      wrap_up();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, unmapped place included
      foreach (offs[i]) rd_chk(offs[i], 32'h0);
      check({30'h0, hresp, hreadyout}, 32'h1);
      wr(8'h1c, 32'hffff_ffff);
      rd_chk(8'h1c, 32'h0);
      // a transfer without select must leave the buffer alone
      sel = 1'b0;
      wr(OFF_BUFFER, 32'h0000_0555);
      sel = 1'b1;
      rd_chk(OFF_BUFFER, 32'h0);
      wr(OFF_BUFFER, 32'hffff_fabc);
      rd_chk(OFF_BUFFER, 32'h0000_0abc);
      wr(OFF_ENABLE, 32'h2);
      rd_chk(OFF_ENABLE, 32'h3);
      wr(OFF_ENABLE, 32'h1);
      rd_chk(OFF_ENABLE, 32'h1);
      // reload on overflow from the preset buffer
      wr(OFF_BUFFER, 32'hffe);
      wr(OFF_CONTROL, 32'h21);
      rd_chk(OFF_CONTROL, 32'h21);
      base = ad_cnt;
      wait_req(1'b0);
      check(32'(clock_irq_request), 32'h1);
      check(ad_cnt, base + 1);
      check(32'(clock_skip_request), 32'h0);
      rd_chk(OFF_COUNT, 32'hffe);
      rd_chk(OFF_STATUS, 32'h1);
      repeat (3) @(posedge hclk);
      check(32'(clock_irq_request), 32'h0);
      wr(OFF_ENABLE, 32'h2);
      wait_req(1'b1);
      check(32'(clock_skip_request), 32'h1);
      check(32'(clock_irq_request), 32'h1);
      rd_chk(OFF_STATUS, 32'h1);
      // without reload the counter wraps to zero two counts after the 0xffe preset
      wr(OFF_CONTROL, 32'h01);
      wait_req(1'b0);
      rd_chk(OFF_COUNT, 32'h0);
      rd_chk(OFF_STATUS, 32'h1);
      wr(OFF_ENABLE, 32'h0);
      wr(OFF_BUFFER, 32'h0);
      // ten tick periods at 400 kHz and 100 kHz; phase allows one either way
      for (int i = 0; i < 2; i++) begin
         per = (i == 0) ? OSC_DIV : OSC_DIV * 4;
         wr(OFF_CONTROL, 32'(i + 1));
         repeat (10 * per) @(posedge hclk);
         xfer(1'b0, OFF_COUNT, 32'h0, rd);
         check(32'(rd >= 9 && rd <= 11), 32'h1);
      end
      wr(OFF_CONTROL, 32'h07);
      repeat (600) @(posedge hclk);
      rd_chk(OFF_COUNT, 32'h0);
      rd_chk(OFF_STATUS, 32'h0);
      base = ad_cnt;
      wr(OFF_CONTROL, 32'h08);
      repeat (3) @(posedge hclk);
      check(ad_cnt, base + 1);
      // channel one counts under rate 6; copies stay suppressed
      wr(OFF_CONTROL, 32'h16);
      i_src.fire(0);
      i_src.fire(0);
      rd_chk(OFF_COUNT, 32'h2);
      rd_chk(OFF_BUFFER, 32'h0);
      i_src.fire(1);
      i_src.fire(2);
      rd_chk(OFF_COUNT, 32'h2);
      rd_chk(OFF_STATUS, 32'h1e);
      rd_chk(OFF_STATUS, 32'h0);
      // capture of the count into the buffer on an event
      wr(OFF_BUFFER, 32'h123);
      wr(OFF_CONTROL, 32'h10);
      wr(OFF_BUFFER, 32'h0);
      i_src.fire(1);
      rd_chk(OFF_BUFFER, 32'h123);
      rd_chk(OFF_STATUS, 32'h4);
      // sticky interrupt status, mask and one-to-clear
      wr(OFF_IRQ_STATUS, 32'hf);
      rd_chk(OFF_IRQ_STATUS, 32'h0);
      i_src.fire(2);
      rd_chk(OFF_IRQ_STATUS, 32'h8);
      @(negedge hclk);
      check(32'(irq), 32'h0);
      wr(OFF_IRQ_MASK, 32'h8);
      rd_chk(OFF_IRQ_MASK, 32'h8);
      @(negedge hclk);
      check(32'(irq), 32'h1);
      wr(OFF_IRQ_STATUS, 32'h8);
      @(negedge hclk);
      check(32'(irq), 32'h0);
      rd_chk(OFF_IRQ_STATUS, 32'h0);
      wrap_up();
   end
endmodule
